/* File: src/sbh_pkg.sv */
// Purpose: Shared constants and types for the strobed burst host port
// Assumes: 200 MHz CORE_CLK, device pins synchronous to it
// Notes: Strobe timing counts derive from times in nanoseconds
package sbh_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ADDR_SETUP_NS = 20;
  localparam int unsigned ACK_TIMEOUT_NS = 2000;
  localparam int unsigned ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  // ********************************
  // States
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LATCH = 3'b010,
    ST_STROBE = 3'b011,
    ST_WAIT_ACK = 3'b100,
    ST_RELEASE = 3'b101,
    ST_END = 3'b110
  } sbh_state_e;
endpackage

/* File: src/sbh_timer_if.sv */
// Purpose: Carries timer load and expiry between host engine and timer
// Assumes: Single clock domain
// Notes: Engine drives load, timer answers done
`timescale 1ns/1ps
interface sbh_timer_if;
  logic load;
  logic [9:0] count;
  logic done;
  modport engine (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

/* File: src/sbh_timer.sv */
// Purpose: Down counter for strobe setup and acknowledge timeout
// Assumes: Synchronous active-high reset
// Notes: done is high while the count stands at zero and load is low
`timescale 1ns/1ps
module sbh_timer
  import sbh_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Engine link
  sbh_timer_if.timer tif
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt_r;
  } sbh_tmr_s;
  sbh_tmr_s q_r;
  sbh_tmr_s q_nxt;
  always_comb
  begin
    q_nxt = q_r;
    if (tif.load)
    begin
      q_nxt.cnt_r = tif.count;
    end
    else if (q_r.cnt_r != CNT_ZERO)
    begin
      q_nxt.cnt_r = q_r.cnt_r - CNT_ONE;
    end
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end
  assign tif.done = (q_r.cnt_r == CNT_ZERO) && !tif.load;
endmodule // sbh_timer

/* File: src/sbh_host.sv */
// Purpose: Host controller that runs read and write bursts on the strobed host port
// Assumes: Device pins synchronous to CORE_CLK; bus style select tied high by the host
// Notes: One burst per request; length counts bytes, at least one
//
// What this block and the device do
// [RL1] Falling address strobe ends a burst; device stops incrementing.
// [RL2] Host drives address strobe low to open a burst.
// [RL3] Host presents start address while address strobe is low.
// [RL4] Chip select goes low together with the start address.
// [RL5] Host raises address strobe after setup; device latches start address.
// [RL6] Write burst: read/not-write low before data strobe falls.
// [RL7] Write data is on the data bus before data strobe falls.
// [RL8] Device takes write data and releases its drivers on strobe.
// [RL9] Device acknowledges once write data has had its setup.
// [RL10] Host raises data strobe after acknowledge; data is committed.
// [RL11] Later writes keep address strobe high, next byte before strobe.
// [RL12] Each later data strobe increments the device address.
// [RL13] Read/not-write stays low for the whole write burst.
// [RL14] Each later write waits for acknowledge then raises strobe.
// [RL15] Strobe and acknowledge style needs bus style select high.
// [RL16] Each later read strobe increments address, device drives new data.
// [RL17] Read: device drives data, then acknowledges valid data.
// [RL18] Device drops acknowledge once data strobe rises.
// [RL19] Device ignores strobe and floats data while chip select high.
`timescale 1ns/1ps
module sbh_host
  import sbh_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // User request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [sbh_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [7:0] REQ_LEN,
  // User write data
  input wire logic [sbh_pkg::DATA_W-1:0] WR_DATA,
  output logic WR_TAKE,
  // User read data and status
  output logic [sbh_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic TIMEOUT_ERR,
  // Device pins
  output logic BUS_STYLE_SELECT,
  output logic ADDR_LATCH_STROBE_N,
  output logic CS_N,
  output logic RD_WR_N,
  output logic DATA_STROBE_N,
  output logic [sbh_pkg::ADDR_W-1:0] ADDR,
  output logic [sbh_pkg::DATA_W-1:0] DATA_O,
  output logic DATA_OE,
  input wire logic [sbh_pkg::DATA_W-1:0] DATA_I,
  input wire logic TRANSFER_ACK_N
);
  import sbh_pkg::*;
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    sbh_state_e st_r;
    logic write_r;
    logic [7:0] left_r;
    logic as_n_r;
    logic cs_n_r;
    logic rw_r;
    logic ds_n_r;
    logic oe_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] dout_r;
    logic [DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic done_r;
    logic err_r;
  } sbh_host_s;
  sbh_host_s q_r;
  sbh_host_s q_nxt;
  sbh_timer_if tif ();
  sbh_timer u_timer (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .tif(tif)
  );
  logic ack;
  logic take;
  assign ack = !TRANSFER_ACK_N;
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rvalid_r = 1'b0;
    q_nxt.done_r = 1'b0;
    tif.load = 1'b0;
    tif.count = CNT_ZERO;
    take = 1'b0;
    unique case (q_r.st_r)
      ST_IDLE:
      begin
        if (REQ_VALID && REQ_LEN != LEN_ZERO)
        begin
          q_nxt.write_r = REQ_WRITE;
          q_nxt.left_r = REQ_LEN;
          q_nxt.as_n_r = 1'b0; // [RL2]
          q_nxt.cs_n_r = 1'b0; // [RL4]
          q_nxt.addr_r = REQ_ADDR; // [RL3]
          q_nxt.err_r = 1'b0;
          tif.load = 1'b1;
          tif.count = CNT_W'(ADDR_SETUP_CYC);
          q_nxt.st_r = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (tif.done)
        begin
          q_nxt.as_n_r = 1'b1; // [RL5]
          q_nxt.rw_r = !q_r.write_r; // [RL6] [RL13]
          q_nxt.st_r = ST_LATCH;
        end
      end
      ST_LATCH, ST_RELEASE:
      begin
        // Wait for the previous acknowledge to clear before a new strobe
        if (!ack) // [RL18]
        begin
          if (q_r.write_r)
          begin
            q_nxt.dout_r = WR_DATA; // [RL7] [RL11]
            q_nxt.oe_r = 1'b1;
            take = 1'b1;
          end
          q_nxt.st_r = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        // Data has stood a full cycle before the strobe falls
        q_nxt.ds_n_r = 1'b0; // [RL8] [RL12] [RL16]
        tif.load = 1'b1;
        tif.count = CNT_W'(ACK_TIMEOUT_CYC);
        q_nxt.st_r = ST_WAIT_ACK;
      end
      ST_WAIT_ACK:
      begin
        if (ack) // [RL9] [RL14] [RL17]
        begin
          q_nxt.ds_n_r = 1'b1; // [RL10]
          if (!q_r.write_r)
          begin
            q_nxt.rdata_r = DATA_I;
            q_nxt.rvalid_r = 1'b1;
          end
          q_nxt.left_r = q_r.left_r - LEN_ONE;
          q_nxt.st_r = (q_r.left_r == LEN_ONE) ? ST_END : ST_RELEASE;
        end
        else if (tif.done)
        begin
          q_nxt.ds_n_r = 1'b1;
          q_nxt.err_r = 1'b1;
          q_nxt.st_r = ST_END;
        end
      end
      ST_END:
      begin
        // Falling address strobe closes the burst, then release the bus
        if (!q_r.as_n_r)
        begin
          q_nxt.as_n_r = 1'b1;
          q_nxt.cs_n_r = 1'b1;
          q_nxt.rw_r = 1'b1;
          q_nxt.done_r = 1'b1;
          q_nxt.st_r = ST_IDLE;
        end
        else
        begin
          q_nxt.oe_r = 1'b0;
          q_nxt.as_n_r = 1'b0; // [RL1]
        end
      end
      default:
      begin
        q_nxt.st_r = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      q_r <= '0;
      q_r.st_r <= ST_IDLE;
      q_r.as_n_r <= 1'b1;
      q_r.cs_n_r <= 1'b1; // [RL19]
      q_r.rw_r <= 1'b1;
      q_r.ds_n_r <= 1'b1;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end
  // ********************************
  // Outputs
  // ********************************
  assign REQ_READY = (q_r.st_r == ST_IDLE);
  assign WR_TAKE = take;
  assign RD_DATA = q_r.rdata_r;
  assign RD_VALID = q_r.rvalid_r;
  assign DONE = q_r.done_r;
  assign TIMEOUT_ERR = q_r.err_r;
  assign BUS_STYLE_SELECT = 1'b1; // [RL15]
  assign ADDR_LATCH_STROBE_N = q_r.as_n_r;
  assign CS_N = q_r.cs_n_r;
  assign RD_WR_N = q_r.rw_r;
  assign DATA_STROBE_N = q_r.ds_n_r;
  assign ADDR = q_r.addr_r;
  assign DATA_O = q_r.dout_r;
  assign DATA_OE = q_r.oe_r;
  // ********************************
  // Checks
  // ********************************
  AST_CS_WITH_ADDR: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL4]
    $fell(ADDR_LATCH_STROBE_N) && $past(q_r.st_r) == ST_IDLE |-> !CS_N)
    else $error("Chip select not low with start address");
  AST_AS_SETUP: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL5]
    $fell(ADDR_LATCH_STROBE_N) && $fell(CS_N) |-> (!ADDR_LATCH_STROBE_N)[*4])
    else $error("Address strobe rose before setup");
  AST_WR_DATA_BEFORE_DS: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL7]
    $fell(DATA_STROBE_N) && !RD_WR_N |-> DATA_OE && $stable(DATA_O))
    else $error("Write data not settled at strobe");
  AST_RW_LOW_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL13]
    !DATA_STROBE_N && q_r.write_r |-> !RD_WR_N)
    else $error("Read/not-write rose during write burst");
  AST_DS_RISE_ON_ACK: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL10]
    !DATA_STROBE_N && !TRANSFER_ACK_N |=> DATA_STROBE_N)
    else $error("Data strobe held after acknowledge");
  AST_AS_HIGH_IN_BURST: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL11]
    !DATA_STROBE_N |-> ADDR_LATCH_STROBE_N && !CS_N)
    else $error("Address strobe low during data strobe");
  AST_DS_BOUNDED: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL14]
    $fell(DATA_STROBE_N) |-> ##[1:401] DATA_STROBE_N)
    else $error("Data strobe stuck low");
  AST_END_FALL: assert property (@(posedge CORE_CLK) disable iff (RST) // [RL1]
    DONE |-> $past(ADDR_LATCH_STROBE_N) == 1'b0 && DATA_STROBE_N)
    else $error("Burst ended without falling address strobe");
endmodule // sbh_host

/* File: verif/sbh_dev_model.sv */
// Purpose: Device side of the strobed host port
// Assumes: Pins sampled on CORE_CLK
// Notes: Ack delay and silence come from the bench
`timescale 1ns/1ps
module sbh_dev_model
  import sbh_pkg::*;
(
  // Clock
  input wire logic CORE_CLK,
  // Host pins
  input wire logic ADDR_LATCH_STROBE_N,
  input wire logic CS_N,
  input wire logic RD_WR_N,
  input wire logic DATA_STROBE_N,
  input wire logic [sbh_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sbh_pkg::DATA_W-1:0] DATA_O,
  input wire logic DATA_OE,
  // Bench control
  input wire logic [3:0] ACK_DLY,
  input wire logic MUTE,
  // Device answers
  output logic [sbh_pkg::DATA_W-1:0] DATA_I,
  output logic TRANSFER_ACK_N = 1'b1
);
  logic [DATA_W-1:0] mem [0:2**ADDR_W-1];
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] last = DATA_ZERO;
  logic as_q = 1'b1;
  logic ds_q = 1'b1;
  logic first = 1'b0;
  logic open = 1'b0;
  logic [3:0] cnt = 4'h0;
  wire drv = !CS_N && !DATA_STROBE_N && RD_WR_N;
  // Released bus shows the inverse of the last byte, never a held value
  assign DATA_I = drv ? mem[adr] : ~last;
  always @(posedge CORE_CLK)
  begin
    as_q <= ADDR_LATCH_STROBE_N;
    ds_q <= DATA_STROBE_N;
    last <= DATA_I;
    if (!CS_N)
    begin
      if (!ADDR_LATCH_STROBE_N && as_q) open <= 1'b0;
      if (ADDR_LATCH_STROBE_N && !as_q)
      begin
        adr <= ADDR;
        open <= 1'b1;
        first <= 1'b1;
      end
      if (!DATA_STROBE_N && ds_q && open)
      begin
        cnt <= 4'h0;
        first <= 1'b0;
        if (!first) adr <= adr + ADDR_ONE;
      end
      else if (!DATA_STROBE_N && open && !MUTE && cnt >= ACK_DLY) TRANSFER_ACK_N <= 1'b0;
      else if (!DATA_STROBE_N) cnt <= cnt + 4'h1;
      if (!DATA_STROBE_N && !RD_WR_N && DATA_OE) wd <= DATA_O;
      if (DATA_STROBE_N && !ds_q)
      begin
        TRANSFER_ACK_N <= 1'b1;
        if (!RD_WR_N && open) mem[adr] <= wd;
      end
    end
  end
endmodule // sbh_dev_model

/* File: verif/sbh_host_tb.sv */
// Purpose: Self-checking bench for the burst host controller
// Assumes: Device model answers on CORE_CLK
// Notes: Bench memory mirrors every write burst
`timescale 1ns/1ps
module sbh_host_tb;
  import sbh_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [ADDR_W-1:0] REQ_ADDR = ADDR_ZERO;
  logic [7:0] REQ_LEN = LEN_ZERO;
  logic [DATA_W-1:0] WR_DATA = DATA_ZERO;
  logic mute = 1'b0;
  logic took = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [DATA_W-1:0] RD_DATA, DATA_O, DATA_I;
  logic REQ_READY, WR_TAKE, RD_VALID, DONE, TIMEOUT_ERR, BUS_STYLE_SELECT, DATA_OE, TRANSFER_ACK_N;
  logic ADDR_LATCH_STROBE_N, CS_N, RD_WR_N, DATA_STROBE_N;
  logic [ADDR_W-1:0] ADDR, ra;
  int fails = 0;
  int checks = 0;
  int rd_n = 0;
  int tk = 0;
  int i;
  logic [31:0] seed = 32'h310F8666;
  logic [DATA_W-1:0] ref_mem [0:2**ADDR_W-1];
  logic [DATA_W-1:0] wq [$];
  sbh_host i_dut (.CORE_CLK, .RST, .REQ_VALID, .REQ_READY, .REQ_WRITE, .REQ_ADDR, .REQ_LEN, .WR_DATA, .WR_TAKE,
    .RD_DATA, .RD_VALID, .DONE, .TIMEOUT_ERR, .BUS_STYLE_SELECT, .ADDR_LATCH_STROBE_N, .CS_N, .RD_WR_N,
    .DATA_STROBE_N, .ADDR, .DATA_O, .DATA_OE, .DATA_I, .TRANSFER_ACK_N);
  sbh_dev_model i_dev (.CORE_CLK, .ADDR_LATCH_STROBE_N, .CS_N, .RD_WR_N, .DATA_STROBE_N, .ADDR, .DATA_O,
    .DATA_OE, .ACK_DLY(ack_dly), .MUTE(mute), .DATA_I, .TRANSFER_ACK_N);
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One burst; write bytes are random and mirrored in ref_mem
  task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] n);
    int k;
    int lim;
    logic [DATA_W-1:0] b;
    ack_dly = 4'(rnd() % 8);
    for (k = 0; k < n; k++)
      if (wr)
      begin
        b = DATA_W'(rnd());
        wq.push_back(b);
        ref_mem[ADDR_W'(a + k)] = b;
      end
    ra = a;
    rd_n = 0;
    tk = 0;
    REQ_WRITE = wr;
    REQ_ADDR = a;
    REQ_LEN = n;
    REQ_VALID = 1'b1;
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
    // Slowest byte takes about 13 cycles; a silent device adds the 400-cycle timeout
    lim = 16 * n + 500;
    k = 0;
    while (DONE !== 1'b1 && k < lim)
    begin
      @(negedge CORE_CLK);
      k++;
    end
    chk(k < lim, 1'b1);
    if (k >= lim)
    begin
      summarize();
    end
    else
    begin
      if (!mute) chk(wr ? tk : rd_n, n);
      @(negedge CORE_CLK);
    end
  endtask
  always @(negedge CORE_CLK)
  begin
    if (took && wq.size() > 0) void'(wq.pop_front());
    if (took) tk++;
    if (wq.size() > 0) WR_DATA = wq[0];
    took = (WR_TAKE === 1'b1);
    if (CS_N === 1'b1) chk(DATA_STROBE_N, 1'b1);
    if (RD_VALID === 1'b1)
    begin
      chk(RD_DATA, ref_mem[ra]);
      ra++;
      rd_n++;
    end
  end
  always @(negedge DATA_STROBE_N)
  begin
    chk(CS_N, 1'b0);
    if (REQ_WRITE)
    begin
      chk({RD_WR_N, DATA_OE, ADDR_LATCH_STROBE_N}, 3'h3);
    end
  end
  initial
  begin
    #300000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (20) @(negedge CORE_CLK);
    RST = 1'b0;
    chk({BUS_STYLE_SELECT, CS_N, REQ_READY}, 3'h7);
    burst(1'b1, 11'h7FE, 8'h04);
    burst(1'b0, 11'h7FE, 8'h04);
    burst(1'b1, 11'h100, 8'hFF);
    burst(1'b0, 11'h100, 8'hFF);
    for (i = 0; i < 10; i++)
    begin
      REQ_ADDR = ADDR_W'(rnd());
      REQ_LEN = 8'(1 + rnd() % 8);
      burst(1'b1, REQ_ADDR, REQ_LEN);
      burst(1'b0, REQ_ADDR, REQ_LEN);
    end
    REQ_LEN = LEN_ZERO;
    REQ_VALID = 1'b1;
    repeat (10) @(negedge CORE_CLK);
    chk({CS_N, REQ_READY}, 2'h3);
    REQ_VALID = 1'b0;
    mute = 1'b1;
    burst(1'b0, 11'h7FF, 8'h01);
    chk(TIMEOUT_ERR, 1'b1);
    mute = 1'b0;
    burst(1'b0, 11'h7FE, 8'h02);
    chk(TIMEOUT_ERR, 1'b0);
    summarize();
  end
endmodule // sbh_host_tb
